// ---- design/umcs_top.sv ----
// Modem control and modem status registers of one UART channel
// Behaviour
// RULE1 - Control bit 7 picks the baud clock feed: every input clock when 0, one in four when 1.
// RULE2 - Control bit 6 opens access to the transmission-control and trigger-level registers.
// RULE3 - Control bit 5 enables resume-on-any-character for software flow control.
// RULE4 - Control bits 7 to 5 take a write only while the enhanced-feature write enable is set.
// RULE5 - Control bit 4 selects internal loop-back of control bits and transmit into receive.
// RULE6 - Control bit 3 high drives the interrupt outputs and pulls the general output low.
// RULE7 - Control bit 2 enables the FIFO-ready summary register.
// RULE8 - Control bit 1 drives request-to-send low, unless automatic flow control owns it.
// RULE9 - Control bit 0 drives data-terminal-ready low when set.
// RULE10 - In normal mode status bits 7 to 4 read the inverted carrier, ring, ready, clear pins.
// RULE11 - In loop-back status bits 7, 6, 5, 4 read control bits 3, 2, 0, 1.
// RULE12 - Status bits 3, 1, 0 set on any change of their source and clear on a status read.
// RULE13 - Status bit 2 sets only on a rising ring source and clears on a status read.
// RULE14 - The modem interrupt enable gates the change bits onto the interrupt output.
// RULE15 - A change in the same cycle as a status read survives the read clear.
`default_nettype none
`include "umcs_map.svh"
module umcs_top (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Host register port
  input wire umcs_pkg::umcs_bus_t bus,
  output logic [7:0] rdata,
  // Context from neighbouring blocks
  input wire logic feature_wr_en,
  input wire logic modem_irq_en,
  input wire logic auto_rts_en,
  input wire logic auto_rts_n,
  input wire logic tx_in,
  input wire logic rx_pin,
  // Modem pins
  input wire umcs_pkg::umcs_modem_in_t modem_in,
  output umcs_pkg::umcs_modem_out_t modem_out,
  // Interrupt pin, enable low while driven
  output logic int_o,
  output logic int_oe_n,
  // Controls to the rest of the channel
  output logic rx_core,
  output logic baud_tick,
  output logic flow_table_en,
  output logic xon_any,
  output logic fifo_rdy_en
);
  import umcs_pkg::*;

  localparam int unsigned PRE_W = $clog2(`UMCS_PRESCALE);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(`UMCS_PRESCALE - 1);

  // Status source: inverted pins, or looped control bits
  function automatic logic [3:0] umcs_src(input logic [7:0] ctl, input umcs_modem_in_t pins);
    if (ctl[`UMCS_CTL_LOOP]) begin
      umcs_src = {ctl[`UMCS_CTL_IRQOUT], ctl[`UMCS_CTL_FIFORDY], ctl[`UMCS_CTL_DTR],
                  ctl[`UMCS_CTL_RTS]}; // RULE11
    end else begin
      umcs_src = ~{pins.carrier_detect_n, pins.ring_indicator_n,
                   pins.dsr_n, pins.cts_n}; // RULE10
    end
  endfunction : umcs_src

  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [3:0] delta_q;
  logic [3:0] delta_d;
  logic [7:0] rdata_d;
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_d;
  umcs_modem_out_t mo_d;
  logic int_d;
  logic int_oe_n_d;
  logic rx_core_d;
  logic tick_d;
  logic [3:0] src;
  logic [3:0] chg;
  logic wr_ctl;
  logic rd_stat;

  assign wr_ctl = ce & bus.wr & (bus.addr == `UMCS_ADDR_CTRL);
  assign rd_stat = ce & bus.rd & (bus.addr == `UMCS_ADDR_STAT);
  assign src = umcs_src(ctl_q, modem_in);

  umcs_delta u_delta (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .src(src),
    .chg(chg)
  );

  // Register next state
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d[4:0] = bus.wdata[4:0];
      if (feature_wr_en) begin
        ctl_d[7:5] = bus.wdata[7:5]; // RULE4
      end
    end
    // Set wins over the read clear so no edge is lost
    delta_d = (rd_stat ? 4'h0 : delta_q) | chg; // RULE12 RULE13 RULE15
    rdata_d = rdata;
    if (ce && bus.rd) begin
      case (bus.addr)
        `UMCS_ADDR_CTRL: rdata_d = ctl_q;
        `UMCS_ADDR_STAT: rdata_d = {src, delta_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Pin and control next state, aligned with the register update except the baud tick, which follows ctl_q a cycle later
  always_comb begin
    pre_d = pre_q;
    tick_d = baud_tick;
    if (ce) begin
      pre_d = (pre_q == PRE_LAST) ? '0 : pre_q + 1'b1;
      tick_d = ~ctl_q[`UMCS_CTL_CLKSEL] | (pre_q == PRE_LAST); // RULE1
    end
    mo_d.rts_n = auto_rts_en ? auto_rts_n : ~ctl_d[`UMCS_CTL_RTS]; // RULE8
    mo_d.dtr_n = ~ctl_d[`UMCS_CTL_DTR]; // RULE9
    mo_d.general_output_pin_n = ~ctl_d[`UMCS_CTL_IRQOUT]; // RULE6
    int_oe_n_d = ~ctl_d[`UMCS_CTL_IRQOUT]; // RULE6
    int_d = modem_irq_en & (|delta_d); // RULE14
    rx_core_d = ctl_d[`UMCS_CTL_LOOP] ? tx_in : rx_pin; // RULE5
    if (!ce) begin
      mo_d = modem_out;
      int_oe_n_d = int_oe_n;
      int_d = int_o;
      rx_core_d = rx_core;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctl_q <= `UMCS_CTL_RST;
      delta_q <= 4'h0;
      rdata <= 8'h00;
      pre_q <= '0;
      baud_tick <= 1'b0;
      modem_out <= '1;
      int_o <= 1'b0;
      int_oe_n <= 1'b1;
      rx_core <= 1'b1;
      flow_table_en <= 1'b0;
      xon_any <= 1'b0;
      fifo_rdy_en <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      delta_q <= delta_d;
      rdata <= rdata_d;
      pre_q <= pre_d;
      baud_tick <= tick_d;
      modem_out <= mo_d;
      int_o <= int_d;
      int_oe_n <= int_oe_n_d;
      rx_core <= rx_core_d;
      flow_table_en <= ctl_d[`UMCS_CTL_FLOWTAB]; // RULE2
      xon_any <= ctl_d[`UMCS_CTL_XONANY]; // RULE3
      fifo_rdy_en <= ctl_d[`UMCS_CTL_FIFORDY]; // RULE7
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_clk_sel;
    (ce && !ctl_q[`UMCS_CTL_CLKSEL]) |=> baud_tick;
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("baud tick missing in divide-by-1"); // RULE1
  property p_ctl_out;
    flow_table_en == ctl_q[6] && xon_any == ctl_q[5] && fifo_rdy_en == ctl_q[2];
  endproperty
  a_ctl_out: assert property (p_ctl_out) else $error("control outputs off register"); // RULE7
  property p_lock;
    (wr_ctl && !feature_wr_en) |=> ctl_q[7:5] == $past(ctl_q[7:5]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked bits changed"); // RULE4
  property p_unlock;
    (wr_ctl && feature_wr_en) |=> flow_table_en == $past(bus.wdata[6]) &&
                                  xon_any == $past(bus.wdata[5]);
  endproperty
  a_unlock: assert property (p_unlock) else $error("enabled write lost"); // RULE2
  property p_loop_rx;
    (ce && ctl_q[4] && !wr_ctl) |=> rx_core == $past(tx_in);
  endproperty
  a_loop_rx: assert property (p_loop_rx) else $error("loop-back receive wrong"); // RULE5
  property p_irq_pin;
    int_oe_n == ~ctl_q[3] && modem_out.general_output_pin_n == ~ctl_q[3];
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin or output pin wrong"); // RULE6
  property p_rts_dtr;
    (ce && !auto_rts_en) |=> modem_out.rts_n == ~ctl_q[1] && modem_out.dtr_n == ~ctl_q[0];
  endproperty
  a_rts_dtr: assert property (p_rts_dtr) else $error("rts or dtr wrong"); // RULE8
  property p_norm_rd;
    (rd_stat && !ctl_q[4]) |=> rdata[7:4] == ~$past({modem_in.carrier_detect_n,
                                                     modem_in.ring_indicator_n,
                                                     modem_in.dsr_n, modem_in.cts_n});
  endproperty
  a_norm_rd: assert property (p_norm_rd) else $error("normal status read wrong"); // RULE10
  property p_loop_rd;
    (rd_stat && ctl_q[4]) |=> rdata[7:4] == {$past(ctl_q[3]), $past(ctl_q[2]),
                                             $past(ctl_q[0]), $past(ctl_q[1])};
  endproperty
  a_loop_rd: assert property (p_loop_rd) else $error("loop status read wrong"); // RULE11
  property p_rd_clr;
    (rd_stat && chg == 4'h0) |=> delta_q == 4'h0;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("read did not clear"); // RULE13
  property p_keep;
    (rd_stat && chg[1]) |=> delta_q[1] ##1 (rdata[1] || !$past(rd_stat));
  endproperty
  a_keep: assert property (p_keep) else $error("change lost under read"); // RULE15
  property p_irq;
    (ce && !modem_irq_en) |=> !int_o;
  endproperty
  a_irq: assert property (p_irq) else $error("modem interrupt not gated"); // RULE14

  c_loop: cover property (wr_ctl && bus.wdata[4] ##1 rd_stat);
  c_race: cover property (rd_stat && |chg);
  c_div4: cover property (ctl_q[7] && baud_tick);
endmodule : umcs_top
`default_nettype wire

// ---- design/umcs_map.svh ----
// Register offsets, field positions, reset values and counts of the modem control block
`ifndef UMCS_MAP_SVH
`define UMCS_MAP_SVH

`define UMCS_ADDR_W 3
`define UMCS_ADDR_CTRL 3'h4
`define UMCS_ADDR_STAT 3'h6

`define UMCS_CTL_CLKSEL 7
`define UMCS_CTL_FLOWTAB 6
`define UMCS_CTL_XONANY 5
`define UMCS_CTL_LOOP 4
`define UMCS_CTL_IRQOUT 3
`define UMCS_CTL_FIFORDY 2
`define UMCS_CTL_RTS 1
`define UMCS_CTL_DTR 0

`define UMCS_STS_CHG_CARRIER 3
`define UMCS_STS_CHG_RING 2
`define UMCS_STS_CHG_DSR 1
`define UMCS_STS_CHG_CTS 0

`define UMCS_CTL_RST 8'h00
`define UMCS_STS_RST 8'h00
`define UMCS_PRESCALE 4

`endif

// ---- design/umcs_pkg.sv ----
// Types shared by the modem control block
`default_nettype none
package umcs_pkg;
  // Active-low modem inputs
  typedef struct packed {
    logic carrier_detect_n;
    logic ring_indicator_n;
    logic dsr_n;
    logic cts_n;
  } umcs_modem_in_t;
  // Active-low modem and general outputs
  typedef struct packed {
    logic rts_n;
    logic dtr_n;
    logic general_output_pin_n;
  } umcs_modem_out_t;
  // Host register port request
  typedef struct packed {
    logic [2:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } umcs_bus_t;
endpackage : umcs_pkg
`default_nettype wire

// ---- design/umcs_delta.sv ----
// Change detector for the four modem status sources
`default_nettype none
module umcs_delta (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Sources, order carrier ring ready clear, active high
  input wire logic [3:0] src,
  // Change events in status bit order
  output logic [3:0] chg
);
  logic [3:0] prev_q;
  logic [3:0] prev_d;

  always_comb begin
    prev_d = ce ? src : prev_q;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= 4'h0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // Ring flags only a rising source; the rest flag both directions
  always_comb begin
    chg[3] = ce & (src[3] ^ prev_q[3]); // RULE12
    chg[2] = ce & src[2] & ~prev_q[2]; // RULE13
    chg[1] = ce & (src[1] ^ prev_q[1]); // RULE12
    chg[0] = ce & (src[0] ^ prev_q[0]); // RULE12
  end
endmodule : umcs_delta
`default_nettype wire

// ---- dv/umcs_modem_model.sv ----
// Modem side model: echoes handshake outputs back after a delay
`default_nettype none
module umcs_modem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Lines from the channel
  input wire umcs_pkg::umcs_modem_out_t modem_out,
  // Carrier and ring asked for by the bench
  input wire logic carrier,
  input wire logic ring,
  // Lines to the channel
  output umcs_pkg::umcs_modem_in_t modem_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import umcs_pkg::*;
  // Two cycle lag, so a slow data set is seen, not an instant mirror
  logic [1:0] d1_q, d2_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      d1_q <= 2'h3;
      d2_q <= 2'h3;
    end else begin
      d1_q <= {modem_out.rts_n, modem_out.dtr_n};
      d2_q <= d1_q;
    end
  end
  assign modem_in = {~carrier, ~ring, d2_q[0], d2_q[1]};
endmodule : umcs_modem_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench of the modem control block
`default_nettype none
`include "umcs_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import umcs_pkg::*;
  logic mclk, nrst, ce, feature_wr_en, modem_irq_en, auto_rts_en, auto_rts_n;
  logic tx_in, rx_pin, carrier, ring;
  logic int_o, int_oe_n, rx_core, baud_tick, flow_table_en, xon_any, fifo_rdy_en;
  logic [7:0] rdata;
  umcs_bus_t bus;
  umcs_modem_in_t modem_in;
  umcs_modem_out_t modem_out;
  int miscompares = 0;
  int samples_checked = 0;
  umcs_top umcs_top_inst (.mclk(mclk), .nrst(nrst), .ce(ce), .bus(bus), .rdata(rdata),
    .feature_wr_en(feature_wr_en), .modem_irq_en(modem_irq_en),
    .auto_rts_en(auto_rts_en), .auto_rts_n(auto_rts_n),
    .tx_in(tx_in), .rx_pin(rx_pin), .modem_in(modem_in), .modem_out(modem_out),
    .int_o(int_o), .int_oe_n(int_oe_n), .rx_core(rx_core), .baud_tick(baud_tick),
    .flow_table_en(flow_table_en), .xon_any(xon_any), .fifo_rdy_en(fifo_rdy_en));
  umcs_modem_model umcs_modem_model_inst (.mclk(mclk), .nrst(nrst), .modem_out(modem_out),
    .carrier(carrier), .ring(ring), .modem_in(modem_in));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk) bus = '{a, 1'b0, 1'b1, d};
    @(negedge mclk) bus.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(negedge mclk) bus = '{a, 1'b1, 1'b0, 8'h00};
    @(negedge mclk) bus.rd = 1'b0;
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_n
  task automatic ticks(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (8) begin
      @(negedge mclk);
      n = n + {7'h00, baud_tick};
    end
    chk("baud ticks", exp, n);
  endtask : ticks
  task automatic t_ctl();
    wr(`UMCS_ADDR_CTRL, 8'he0);
    rd(`UMCS_ADDR_CTRL);
    chk("control locked", 8'h00, rdata);
    feature_wr_en = 1'b1;
    wr(`UMCS_ADDR_CTRL, 8'he0);
    rd(`UMCS_ADDR_CTRL);
    chk("control open", 8'he0, rdata);
    chk("flow table en", 8'h01, {7'h00, flow_table_en});
    chk("xon any", 8'h01, {7'h00, xon_any});
    ticks(8'h02);
    wr(`UMCS_ADDR_CTRL, 8'h00);
    chk("xon any off", 8'h00, {6'h00, xon_any, flow_table_en});
    ticks(8'h08);
  endtask : t_ctl
  task automatic t_freeze();
    @(negedge mclk) ce = 1'b0;
    bus = '{`UMCS_ADDR_CTRL, 1'b0, 1'b1, 8'h03};
    @(negedge mclk) bus.wr = 1'b0;
    ce = 1'b1;
    chk("frozen pins", 8'h07, {5'h00, modem_out});
    rd(`UMCS_ADDR_CTRL);
    chk("frozen control", 8'h00, rdata);
  endtask : t_freeze
  task automatic t_out();
    wr(`UMCS_ADDR_CTRL, 8'h0f);
    wait_n(4);
    chk("pins on", 8'h00, {5'h00, modem_out});
    chk("int oe fifo", 8'h01, {6'h00, int_oe_n, fifo_rdy_en});
    auto_rts_en = 1'b1;
    wait_n(4);
    chk("auto rts", 8'h04, {5'h00, modem_out});
    auto_rts_en = 1'b0;
    wr(`UMCS_ADDR_CTRL, 8'h00);
    wait_n(4);
    chk("pins off", 8'h07, {5'h00, modem_out});
    chk("int oe off", 8'h02, {6'h00, int_oe_n, fifo_rdy_en});
    chk("int raised", 8'h01, {7'h00, int_o});
    rd(`UMCS_ADDR_STAT);
    chk("status deltas", 8'h03, rdata);
    chk("int cleared", 8'h00, {7'h00, int_o});
  endtask : t_out
  task automatic t_race();
    modem_irq_en = 1'b0;
    @(negedge mclk) bus = '{`UMCS_ADDR_STAT, 1'b1, 1'b0, 8'h00};
    carrier = 1'b1;
    @(negedge mclk) bus.rd = 1'b0;
    chk("read in change", 8'h00, {4'h0, rdata[3:0]});
    chk("int gated", 8'h00, {7'h00, int_o});
    rd(`UMCS_ADDR_STAT);
    chk("change kept", 8'h88, rdata);
  endtask : t_race
  task automatic t_loop();
    wr(`UMCS_ADDR_CTRL, 8'h10);
    tx_in = 1'b0;
    wait_n(2);
    chk("loop rx", 8'h00, {7'h00, rx_core});
    tx_in = 1'b1;
    rd(`UMCS_ADDR_STAT);
    chk("loop jump", 8'h08, rdata);
    wr(`UMCS_ADDR_CTRL, 8'h14);
    rd(`UMCS_ADDR_STAT);
    chk("ring rise", 8'h44, rdata);
    wr(`UMCS_ADDR_CTRL, 8'h10);
    rd(`UMCS_ADDR_STAT);
    chk("ring fall", 8'h00, rdata);
    wr(`UMCS_ADDR_CTRL, 8'h1b);
    rd(`UMCS_ADDR_STAT);
    chk("loop map", 8'hbb, rdata);
    wr(`UMCS_ADDR_CTRL, 8'h11);
    rd(`UMCS_ADDR_STAT);
    chk("loop ready only", 8'h29, rdata);
    wr(`UMCS_ADDR_CTRL, 8'h00);
    rx_pin = 1'b0;
    wait_n(2);
    chk("normal rx", 8'h00, {7'h00, rx_core});
  endtask : t_loop
  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    // Long enough for all scenarios several times over
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    {nrst, feature_wr_en, auto_rts_en, carrier, ring} = 5'h00;
    {ce, modem_irq_en, auto_rts_n, tx_in, rx_pin} = 5'h1f;
    bus = '0;
    wait_n(12);
    chk("reset pins", 8'h0f, {4'h0, modem_out, int_oe_n});
    nrst = 1'b1;
    t_ctl();
    t_freeze();
    t_out();
    t_race();
    t_loop();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
